/* src/nvsctl_host.sv */
// Summary of operation
// RULE1 - device stores the array before sleeping once sleep pin falls
// RULE2 - no access is issued while sleep pin is low
// RULE3 - after raising sleep pin, wait the wake delay before any access
// RULE4 - device skips the sleep store when nothing was written
// RULE5 - sleep pin low at power-up only tristates device outputs
// RULE6 - selected only when first select low and second select high
// RULE7 - byte lanes driven per organization; device ignores others
// RULE8 - sequence addresses only matter in bits 14 down to 2
// RULE9 - six consecutive reads in listed order with write strobe high
// RULE10 - five prefix reads return normal array data
// RULE11 - sixth read at 0x8B45 disables power-fail store
// RULE12 - sixth read at 0x4B46 re-enables power-fail store
// RULE13 - a changed power-fail store setting needs a following software store
// RULE14 - initial state: power-fail store enabled, all cells 0x00
// RULE15 - device blocks writes and stores during low voltage
// RULE16 - writes held off for post-store access delay after store or recall
// RULE17 - each sequence read is select-controlled with write strobe high
// RULE18 - sixth read at 0x8FC0 starts a store; device busy for store time
// RULE19 - sixth read at 0x4C63 starts a recall
// RULE20 - any other access inside a sequence aborts it
// RULE21 - after abort, a fresh first-prefix read starts a new sequence
module nvsctl_host
  import nvsctl_pkg::*;
#(
  parameter int ADDR_W      = 21,
  parameter int DATA_W      = 8,
  parameter int LANES       = 1,
  parameter int WAKE_CYC    = WAKE_CYCLES,
  parameter int STORE_CYC   = STORE_CYCLES
) (
  // clock, reset, enable
  input  wire logic              sys_clk_in,
  input  wire logic              resetn_in,
  input  wire logic              clk_en_in,
  // command port
  input  wire logic              cmd_valid_in,
  input  wire nvsctl_cmd_t       cmd_in,
  input  wire logic [ADDR_W-1:0] cmd_addr_in,
  input  wire logic [DATA_W-1:0] cmd_wdata_in,
  input  wire logic [LANES-1:0]  cmd_lanes_n_in,
  input  wire logic              wake_in,
  output logic                   cmd_ready_out,
  output logic                   rsp_valid_out,
  output logic [DATA_W-1:0]      rsp_rdata_out,
  output logic                   asleep_out,
  // device pins
  output logic [ADDR_W-1:0]      mem_addr_out,
  output logic                   chip_select_first_n_out,
  output logic                   chip_select_second_out,
  output logic                   write_n_out,
  output logic                   output_en_n_out,
  output logic [LANES-1:0]       byte_lane_n_out,
  output logic                   sleep_request_n_out,
  input  wire logic [DATA_W-1:0] mem_data_in,
  output logic [DATA_W-1:0]      mem_data_out,
  output logic                   mem_data_oe_n_out,
  input  wire logic              store_busy_n_in
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [DATA_W-1:0] data_meta;
  logic [DATA_W-1:0] data_sync;
  logic              busy_meta;
  logic              busy_sync;

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      data_meta <= '0;
      data_sync <= '0;
      busy_meta <= 1'b1;
      busy_sync <= 1'b1;
    end else if (clk_en_in) begin
      data_meta <= mem_data_in;
      data_sync <= data_meta;
      busy_meta <= store_busy_n_in;
      busy_sync <= busy_meta;
    end
  end

  // ****************************************
  // state machine
  // ****************************************
  typedef enum logic [2:0] {
    NVSCTL_IDLE,
    NVSCTL_ACCESS,
    NVSCTL_GAP,
    NVSCTL_BUSY,
    NVSCTL_SLEEP,
    NVSCTL_WAKE
  } nvsctl_state_t;

  nvsctl_state_t     state;
  nvsctl_state_t     next_state;
  logic [31:0]       count;
  logic [31:0]       next_count;
  logic [2:0]        step;
  logic              seq_mode;
  nvsctl_cmd_t       cur_cmd;
  logic              cur_write;

  // the sixth address of each special command
  wire logic [15:0] last_addr = (cur_cmd == NVSCTL_CMD_STORE)   ? SEQ_STORE :
                                (cur_cmd == NVSCTL_CMD_RECALL)  ? SEQ_RECALL :
                                (cur_cmd == NVSCTL_CMD_PFS_OFF) ? SEQ_PFS_OFF : SEQ_PFS_ON; // RULE11 RULE12 RULE18 RULE19
  // address of the read after the current step; the first read goes out straight from idle
  wire logic [15:0] seq_addr  = (step == 3'd0) ? SEQ_A2 :
                                (step == 3'd1) ? SEQ_A3 :
                                (step == 3'd2) ? SEQ_A4 :
                                (step == 3'd3) ? SEQ_A5 : last_addr; // RULE9
  wire logic        is_seq    = (cmd_in == NVSCTL_CMD_STORE) || (cmd_in == NVSCTL_CMD_RECALL) ||
                                (cmd_in == NVSCTL_CMD_PFS_OFF) || (cmd_in == NVSCTL_CMD_PFS_ON);
  wire logic        last_step = (step == 3'(SEQ_LEN - 1));
  // a sequence holds the port until all six reads are out, so nothing intervenes
  wire logic        accept    = (state == NVSCTL_IDLE) && cmd_valid_in && busy_sync; // RULE16 RULE20
  wire logic        in_seq_gap = (state == NVSCTL_GAP) && seq_mode && !last_step;

  always_comb begin
    next_state = state;
    next_count = count;
    case (state)
      NVSCTL_IDLE: begin
        if (accept) begin
          next_state = (cmd_in == NVSCTL_CMD_SLEEP) ? NVSCTL_SLEEP : NVSCTL_ACCESS; // RULE1
          next_count = 32'(ACCESS_CYCLES);
        end
      end
      NVSCTL_ACCESS: begin
        if (count <= 32'd1) begin
          next_state = NVSCTL_GAP;
          next_count = 32'(RECOVER_CYCLES);
        end else begin
          next_count = count - 32'd1;
        end
      end
      NVSCTL_GAP: begin
        if (count > 32'd1) begin
          next_count = count - 32'd1;
        end else if (in_seq_gap) begin
          next_state = NVSCTL_ACCESS; // RULE9 RULE21
          next_count = 32'(ACCESS_CYCLES);
        end else if (seq_mode && (cur_cmd == NVSCTL_CMD_STORE || cur_cmd == NVSCTL_CMD_RECALL)) begin
          next_state = NVSCTL_BUSY; // RULE13 RULE18 RULE19
          next_count = 32'(STORE_CYC);
        end else begin
          next_state = NVSCTL_IDLE;
        end
      end
      NVSCTL_BUSY: begin
        // wait out store time, then any busy pin plus post-store delay
        if (count > 32'd1) begin
          next_count = count - 32'd1;
        end else if (busy_sync) begin
          next_state = NVSCTL_WAKE; // RULE16
          next_count = 32'(POST_STORE_CYCLES);
        end
      end
      NVSCTL_SLEEP: begin
        if (wake_in) begin
          next_state = NVSCTL_WAKE; // RULE3
          next_count = 32'(WAKE_CYC);
        end
      end
      NVSCTL_WAKE: begin
        if (count > 32'd1) begin
          next_count = count - 32'd1;
        end else begin
          next_state = NVSCTL_IDLE;
        end
      end
      default: begin
        next_state = NVSCTL_IDLE;
        next_count = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state    <= NVSCTL_IDLE;
      count    <= '0;
    end else if (clk_en_in) begin
      state    <= next_state;
      count    <= next_count;
    end
  end

  // ****************************************
  // command capture and sequence step
  // ****************************************
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cur_cmd   <= NVSCTL_CMD_READ;
      seq_mode  <= 1'b0;
      cur_write <= 1'b0;
      step      <= '0;
    end else if (clk_en_in) begin
      if (accept) begin
        cur_cmd   <= cmd_in;
        seq_mode  <= is_seq;
        cur_write <= (cmd_in == NVSCTL_CMD_WRITE);
        step      <= '0; // RULE21
      end else if (in_seq_gap && count <= 32'd1) begin
        step      <= step + 3'd1;
      end
    end
  end

  // ****************************************
  // pin drive, all from flip-flops
  // ****************************************
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mem_addr_out            <= '0;
      chip_select_first_n_out <= 1'b1;
      chip_select_second_out  <= 1'b0;
      write_n_out             <= 1'b1;
      output_en_n_out         <= 1'b1;
      byte_lane_n_out         <= '1;
      sleep_request_n_out     <= 1'b1; // RULE5
      mem_data_out            <= '0;
      mem_data_oe_n_out       <= 1'b1;
    end else if (clk_en_in) begin
      if (next_state == NVSCTL_ACCESS) begin
        if (state == NVSCTL_IDLE && !is_seq) begin
          mem_addr_out    <= cmd_addr_in;
          mem_data_out    <= cmd_wdata_in;
          byte_lane_n_out <= cmd_lanes_n_in; // RULE7
        end else if (seq_mode || (state == NVSCTL_IDLE && is_seq)) begin
          // upper lines don't care, so drive zero above bit 15
          mem_addr_out    <= ADDR_W'(state == NVSCTL_IDLE ? SEQ_A1 : seq_addr); // RULE8
          byte_lane_n_out <= '0;
        end
        chip_select_first_n_out <= 1'b0; // RULE6 RULE17
        chip_select_second_out  <= 1'b1;
        write_n_out             <= !(state == NVSCTL_IDLE ? cmd_in == NVSCTL_CMD_WRITE : cur_write); // RULE9 RULE17
        output_en_n_out         <= (state == NVSCTL_IDLE ? cmd_in == NVSCTL_CMD_WRITE : cur_write);
        mem_data_oe_n_out       <= !(state == NVSCTL_IDLE ? cmd_in == NVSCTL_CMD_WRITE : cur_write);
      end else begin
        chip_select_first_n_out <= 1'b1;
        chip_select_second_out  <= 1'b0;
        write_n_out             <= 1'b1;
        output_en_n_out         <= 1'b1;
        mem_data_oe_n_out       <= 1'b1;
      end
      sleep_request_n_out <= !(next_state == NVSCTL_SLEEP); // RULE1 RULE2
    end
  end

  // ****************************************
  // read response: sequence reads, prefix reads included, give no response
  // ****************************************
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= '0;
    end else if (clk_en_in) begin
      rsp_valid_out <= 1'b0;
      if (state == NVSCTL_GAP && count <= 32'd1 && !seq_mode) begin
        rsp_valid_out <= 1'b1;
        rsp_rdata_out <= cur_write ? '0 : data_sync; // RULE10
      end
    end
  end

  // ready only when idle, awake and the device is not busy
  assign cmd_ready_out = (state == NVSCTL_IDLE) && busy_sync; // RULE2 RULE15
  assign asleep_out    = (state == NVSCTL_SLEEP);

endmodule : nvsctl_host

/* shared/nvsctl_pkg.sv */
package nvsctl_pkg;
  // ****************************************
  // pin-level timing, in ns and cycles at 50 MHz
  // ****************************************
  localparam int CLK_PERIOD_NS     = 20;
  localparam int ACCESS_TIME_NS    = 45;
  localparam int ACCESS_CYCLES     = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_TIME_NS   = 20;
  localparam int RECOVER_CYCLES    = (RECOVER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_TIME_NS      = 20000;
  localparam int WAKE_CYCLES       = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STORE_TIME_NS     = 8000000;
  localparam int STORE_CYCLES      = (STORE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POST_STORE_NS     = 40;
  localparam int POST_STORE_CYCLES = (POST_STORE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // special sequence addresses, bits 14..2 matter
  // ****************************************
  localparam logic [15:0] SEQ_A1        = 16'h4E38;
  localparam logic [15:0] SEQ_A2        = 16'hB1C7;
  localparam logic [15:0] SEQ_A3        = 16'h83E0;
  localparam logic [15:0] SEQ_A4        = 16'h7C1F;
  localparam logic [15:0] SEQ_A5        = 16'h703F;
  localparam logic [15:0] SEQ_PFS_OFF   = 16'h8B45;
  localparam logic [15:0] SEQ_PFS_ON    = 16'h4B46;
  localparam logic [15:0] SEQ_STORE     = 16'h8FC0;
  localparam logic [15:0] SEQ_RECALL    = 16'h4C63;
  localparam int          SEQ_LEN       = 6;

  // ****************************************
  // host commands
  // ****************************************
  typedef enum logic [2:0] {
    NVSCTL_CMD_READ,
    NVSCTL_CMD_WRITE,
    NVSCTL_CMD_STORE,
    NVSCTL_CMD_RECALL,
    NVSCTL_CMD_PFS_OFF,
    NVSCTL_CMD_PFS_ON,
    NVSCTL_CMD_SLEEP
  } nvsctl_cmd_t;
endpackage : nvsctl_pkg

/* sim/nvsctl_host_properties.sv */
module nvsctl_host_properties
  import nvsctl_pkg::*;
#(
  parameter int ADDR_W = 21
) (
  // clock and reset
  input wire logic              sys_clk_in,
  input wire logic              resetn_in,
  // command side
  input wire logic              clk_en_in,
  input wire logic              cmd_valid_in,
  input wire nvsctl_cmd_t       cmd_in,
  input wire logic              cmd_ready_out,
  input wire logic              rsp_valid_out,
  input wire logic              asleep_out,
  // device pins
  input wire logic [ADDR_W-1:0] mem_addr_out,
  input wire logic              chip_select_first_n_out,
  input wire logic              chip_select_second_out,
  input wire logic              write_n_out,
  input wire logic              output_en_n_out,
  input wire logic              sleep_request_n_out,
  input wire logic              mem_data_oe_n_out,
  input wire logic              store_busy_n_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // pin relations
  // ****************************************
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  wire taken   = clk_en_in && cmd_valid_in && cmd_ready_out;
  wire is_rd   = taken && cmd_in == NVSCTL_CMD_READ;
  wire special = taken && cmd_in inside {NVSCTL_CMD_STORE, NVSCTL_CMD_RECALL, NVSCTL_CMD_PFS_OFF, NVSCTL_CMD_PFS_ON};
  chk_read_pins: assert property (is_rd |=> (!chip_select_first_n_out && chip_select_second_out
    && write_n_out && !output_en_n_out)[*3]) else $error("read pins not held");
  chk_read_answer: assert property (is_rd |-> ##5 rsp_valid_out) else $error("read answer late");
  chk_write_drive: assert property (taken && cmd_in == NVSCTL_CMD_WRITE |=> !write_n_out
    && !mem_data_oe_n_out && chip_select_second_out) else $error("write pins wrong");
  chk_seq_strobe: assert property (special |=> write_n_out[*8]) else $error("strobe low in sequence");
  chk_seq_start: assert property (special |=> mem_addr_out[14:2] == SEQ_A1[14:2]) else $error("bad first step");
  chk_sleep_entry: assert property (taken && cmd_in == NVSCTL_CMD_SLEEP |=> !sleep_request_n_out
    && asleep_out) else $error("sleep not entered");
  chk_sleep_quiet: assert property (!sleep_request_n_out |-> chip_select_first_n_out
    && !cmd_ready_out) else $error("access while asleep");
  chk_wake_wait: assert property ($rose(sleep_request_n_out) |-> !cmd_ready_out[*8]) else $error("woke early");
  // two-flop sync on the busy pin, so the block shows on the third low sample
  chk_busy_block: assert property (!store_busy_n_in[*3] |-> !cmd_ready_out) else $error("ready while busy");
  cover property (is_rd);
  cover property (special && cmd_in == NVSCTL_CMD_STORE);
  cover property (taken && cmd_in == NVSCTL_CMD_SLEEP);
endmodule : nvsctl_host_properties

bind nvsctl_host nvsctl_host_properties #(.ADDR_W(ADDR_W)) u_props (
  .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .clk_en_in(clk_en_in), .cmd_valid_in(cmd_valid_in),
  .cmd_in(cmd_in), .cmd_ready_out(cmd_ready_out), .rsp_valid_out(rsp_valid_out), .asleep_out(asleep_out),
  .mem_addr_out(mem_addr_out), .chip_select_first_n_out(chip_select_first_n_out),
  .chip_select_second_out(chip_select_second_out), .write_n_out(write_n_out), .output_en_n_out(output_en_n_out),
  .sleep_request_n_out(sleep_request_n_out), .mem_data_oe_n_out(mem_data_oe_n_out),
  .store_busy_n_in(store_busy_n_in));

/* sim/nvsctl_dev_model.sv */
module nvsctl_dev_model
  import nvsctl_pkg::*;
#(
  parameter int ADDR_W  = 21,
  parameter int STORE_T = 20
) (
  // pins seen from the device
  input wire logic              sys_clk_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic              cs1_n_in,
  input wire logic              cs2_in,
  input wire logic              we_n_in,
  input wire logic              oe_n_in,
  input wire logic              sleep_n_in,
  input wire logic [7:0]        wdata_in,
  output logic [7:0]            rdata_out,
  output logic                  busy_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [0:65535];
  logic [7:0]  nv [0:65535];
  logic [15:0] seq [0:4] = '{SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4, SEQ_A5};
  logic [7:0]  last = 8'h00;
  logic        pfs_en = 1'b1, nv_pfs = 1'b1, dirty = 1'b0, was_sel = 1'b0, asleep = 1'b0;
  int          step = 0, busy_cnt = 0, n_store = 0;
  wire         sel = !cs1_n_in && cs2_in && sleep_n_in && busy_cnt == 0;
  wire         rd  = sel && we_n_in && !oe_n_in;
  wire [12:0]  a   = addr_in[14:2];
  // released bus shows the inverse of the last value, never a stale copy
  assign rdata_out  = rd ? mem[addr_in[15:0]] : ~last;
  assign busy_n_out = busy_cnt == 0;
  initial foreach (mem[i]) begin
    mem[i] = 8'h00;
    nv[i]  = 8'h00;
  end
  task automatic save();
    nv = mem;
    nv_pfs = pfs_en;
    dirty = 1'b0;
    n_store++;
    busy_cnt = STORE_T;
  endtask : save
  always @(posedge sys_clk_in) begin
    last <= rdata_out;
    if (busy_cnt > 0) busy_cnt--;
    if (sleep_n_in) asleep = 1'b0;
    else if (!asleep) begin
      asleep = 1'b1;
      if (dirty) save();
    end
    if (sel && !we_n_in) begin
      mem[addr_in[15:0]] = wdata_in;
      dirty = 1'b1;
      step = 0;
    end else if (rd && !was_sel) begin
      if (step == 5) begin
        case (a)
          SEQ_STORE[14:2]:   save();
          SEQ_RECALL[14:2]:  begin mem = nv; dirty = 1'b0; busy_cnt = STORE_T; end
          SEQ_PFS_OFF[14:2]: pfs_en = 1'b0;
          SEQ_PFS_ON[14:2]:  pfs_en = 1'b1;
          default: ;
        endcase
        step = 0;
      end else if (a == seq[step][14:2]) step++;
      else step = (a == SEQ_A1[14:2]) ? 1 : 0;
    end
    was_sel = sel;
  end
endmodule : nvsctl_dev_model

/* sim/nvsctl_host_test.sv */
module nvsctl_host_test
  import nvsctl_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk_in = 1'b0, resetn_in = 1'b0, cmd_valid = 1'b0, wake = 1'b0;
  nvsctl_cmd_t cmd = NVSCTL_CMD_READ;
  logic [20:0] addr = 21'h0, mem_addr;
  logic [7:0]  wdata = 8'h00, host_data, dev_data, bus, rdata;
  logic        cmd_ready, rsp_valid, asleep, cs1_n, cs2, we_n, oe_n, sleep_n, data_oe_n, busy_n;
  logic [0:0]  lanes_n;
  logic [7:0]  exp_q [$];
  logic [7:0]  shadow [0:65535];
  logic [7:0]  nv_sh [0:65535];
  logic [31:0] seed = 32'h0C6E;
  int          n_fail = 0, n_compared = 0, cycles = 0;
  assign bus = data_oe_n === 1'b0 ? host_data : dev_data;
  nvsctl_host #(.WAKE_CYC(10), .STORE_CYC(20)) DUT (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .clk_en_in(1'b1), .cmd_valid_in(cmd_valid), .cmd_in(cmd),
    .cmd_addr_in(addr), .cmd_wdata_in(wdata), .cmd_lanes_n_in(1'b0), .wake_in(wake), .cmd_ready_out(cmd_ready),
    .rsp_valid_out(rsp_valid), .rsp_rdata_out(rdata), .asleep_out(asleep), .mem_addr_out(mem_addr),
    .chip_select_first_n_out(cs1_n), .chip_select_second_out(cs2), .write_n_out(we_n), .output_en_n_out(oe_n),
    .byte_lane_n_out(lanes_n), .sleep_request_n_out(sleep_n), .mem_data_in(bus), .mem_data_out(host_data),
    .mem_data_oe_n_out(data_oe_n), .store_busy_n_in(busy_n));
  nvsctl_dev_model dev (.sys_clk_in(sys_clk_in), .addr_in(mem_addr), .cs1_n_in(cs1_n), .cs2_in(cs2),
    .we_n_in(we_n), .oe_n_in(oe_n), .sleep_n_in(sleep_n), .wdata_in(bus), .rdata_out(dev_data), .busy_n_out(busy_n));
  // ****************************************
  // helpers
  // ****************************************
  initial forever #10 sys_clk_in = ~sys_clk_in;
  task automatic print_verdict();
    if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      n_fail++;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, want);
    end
  endtask : check
  task automatic issue(input nvsctl_cmd_t c, input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    cmd_valid <= 1'b1;
    cmd <= c;
    addr <= {5'h00, a};
    wdata <= d;
    do @(negedge sys_clk_in); while (cmd_ready !== 1'b1);
    @(posedge sys_clk_in);
    cmd_valid <= 1'b0;
  endtask : issue
  task automatic rd(input logic [15:0] a);
    exp_q.push_back(shadow[a]);
    issue(NVSCTL_CMD_READ, a, 8'h00);
  endtask : rd
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    shadow[a] = d;
    exp_q.push_back(8'h00);
    issue(NVSCTL_CMD_WRITE, a, d);
  endtask : wr
  task automatic settle(input int n);
    repeat (n) @(negedge sys_clk_in);
    while (exp_q.size() != 0 || (cmd_ready !== 1'b1 && asleep !== 1'b1)) @(negedge sys_clk_in);
  endtask : settle
  task automatic wake_up();
    @(posedge sys_clk_in);
    wake <= 1'b1;
    do @(negedge sys_clk_in); while (cmd_ready !== 1'b1);
    @(posedge sys_clk_in);
    wake <= 1'b0;
  endtask : wake_up
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // a hang ends the run through the same verdict
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      print_verdict();
    end
  end
  // sample on the falling edge, where the registered response has settled
  always @(negedge sys_clk_in) begin
    if (resetn_in && rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("wrong value at %0t: response with nothing pending", $time);
      end else check(rdata, exp_q.pop_front());
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    foreach (shadow[i]) shadow[i] = 8'h00;
    repeat (10) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      rd(seed[15:0]);
      wr(seed[15:0], seed[23:16]);
      rd(seed[15:0]);
    end
    issue(NVSCTL_CMD_PFS_OFF, 16'h0000, 8'h00);
    settle(2);
    check(dev.pfs_en, 1'b0);
    issue(NVSCTL_CMD_STORE, 16'h0000, 8'h00);
    settle(2);
    nv_sh = shadow;
    check(dev.nv_pfs, 1'b0);
    check(dev.n_store, 1);
    issue(NVSCTL_CMD_PFS_ON, 16'h0000, 8'h00);
    settle(2);
    check(dev.pfs_en, 1'b1);
    wr(seed[15:0], ~seed[23:16]);
    issue(NVSCTL_CMD_RECALL, 16'h0000, 8'h00);
    settle(2);
    shadow = nv_sh;
    rd(seed[15:0]);
    wr(seed[15:0], 8'h5A);
    settle(1);
    issue(NVSCTL_CMD_SLEEP, 16'h0000, 8'h00);
    repeat (30) @(negedge sys_clk_in);
    check(dev.n_store, 2);
    wake_up();
    issue(NVSCTL_CMD_SLEEP, 16'h0000, 8'h00);
    repeat (30) @(negedge sys_clk_in);
    check(dev.n_store, 2);
    wake_up();
    rd(seed[15:0]);
    settle(2);
    print_verdict();
  end
endmodule : nvsctl_host_test
